// ### hw/monitor_irq_mask_config_regs.sv
// mask, configuration, intrusion-clear and status copy registers of a hardware monitor
// assumes register requests come from the serial-bus engine on core_clk
`timescale 1ns/10ps
`default_nettype none

module monitor_irq_mask_config_regs
	import monitor_regs_pkg::*;
#(
	parameter int PULSE_CYCLES = INTRUSION_PULSE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_init,
	// register port
	input wire reg_req_s req,
	output reg_rsp_s rsp,
	// event sources from the limit engine
	input wire logic [7:0] first_events,
	input wire fault_in_s faults,
	input wire logic aux_group_irq_mode,
	// pins
	input wire logic [4:0] core_voltage_code,
	input wire logic [1:0] aux_irq_pin,
	input wire logic overtemp_signal_n,
	input wire logic intrusion_flag_in,
	output logic intrusion_flag_out,
	output logic intrusion_flag_oe_n,
	// controls to the rest of the monitor
	output logic alarm_n,
	output logic overtemp_acpi_mode,
	output logic [3:0] first_tachometer_divide,
	output logic [3:0] second_tachometer_divide,
	output logic [7:0] fan_ambient_ctrl,
	output logic [7:0] fan_remote_ctrl
);

	typedef struct packed {
		logic [4:0] code_a;
		logic [4:0] code_b;
		logic [1:0] aux_a;
		logic [1:0] aux_b;
		logic ovt_a;
		logic ovt_b;
		logic intr_a;
		logic intr_b;
		logic intr_prev;
		logic [7:0] mask_first;
		logic [7:0] mask_second;
		logic [3:0] prescale;
		logic [7:0] config2;
		logic [7:0] fan_ambient;
		logic [7:0] fan_remote;
		logic [7:0] status_first;
		logic [7:0] status_second;
		logic clear_busy;
		logic [PULSE_CNT_W-1:0] pulse_cnt;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic alarm_n;
	} state_s;

	state_s q;
	state_s next_q;

	// divide ratio from a two-bit prescaler code
	function automatic logic [3:0] divide_of(input logic [1:0] code);
		logic [3:0] r;
		r = 4'h1;
		case (code)
			2'b00: r = 4'h1;
			2'b01: r = 4'h2;
			2'b10: r = 4'h4;
			default: r = 4'h8;
		endcase
		return r;
	endfunction

	localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(PULSE_CYCLES - 1);

	logic wr_hit;
	logic [7:0] second_flags;
	logic [7:0] first_gated;
	logic [7:0] second_gated;
	logic [1:0] aux_active;
	logic [7:0] read_value;
	logic clear_first;
	logic clear_second;

	always_comb begin
		next_q = q;
		wr_hit = req.wr;
		clear_first = 1'b0;
		clear_second = 1'b0;

		// pin synchronisers
		next_q.code_a = core_voltage_code;
		next_q.code_b = q.code_a;
		next_q.aux_a = aux_irq_pin;
		next_q.aux_b = q.aux_a;
		next_q.ovt_a = overtemp_signal_n;
		next_q.ovt_b = q.ovt_a;
		next_q.intr_a = intrusion_flag_in;
		next_q.intr_b = q.intr_a;
		next_q.intr_prev = q.intr_b;

		// register read, answered one cycle later
		read_value = RST_BYTE;
		if (req.addr == OFS_FAN_AMBIENT) begin
			read_value = q.fan_ambient;
		end else if (req.addr == OFS_FAN_REMOTE) begin
			read_value = q.fan_remote;
		end else if (req.addr == OFS_STATUS_FIRST) begin
			read_value = q.status_first;
			clear_first = req.rd;
		end else if (req.addr == OFS_STATUS_SECOND) begin
			read_value = q.status_second & ST2_VALID;
			clear_second = req.rd;
		end else if (req.addr == OFS_IRQ_MASK_FIRST) begin
			read_value = q.mask_first;
		end else if (req.addr == OFS_IRQ_MASK_SECOND) begin
			read_value = q.mask_second;
		end else if (req.addr == OFS_INTRUSION_CLEAR) begin
			read_value = {q.clear_busy, 7'h00};
		end else if (req.addr == OFS_CORE_CODE_LOW) begin
			read_value = {q.prescale, q.code_b[3:0]};
		end else if (req.addr == OFS_CORE_CODE_HIGH) begin
			read_value = {IDENTITY_PATTERN, q.code_b[4]};
		end else if (req.addr == OFS_SECOND_CONFIG) begin
			read_value = q.config2 & CFG2_VALID;
		end else if (req.addr == OFS_STATUS_FIRST_COPY) begin
			read_value = q.status_first;
		end else if (req.addr == OFS_STATUS_SECOND_COPY) begin
			read_value = q.status_second & ST2_VALID;
		end
		next_q.rsp_valid = req.rd;
		next_q.rsp_data = req.rd ? read_value : q.rsp_data;

		// register writes
		if (wr_hit) begin
			if (req.addr == OFS_FAN_AMBIENT) begin
				if (!q.config2[CFG_LOCK_AMBIENT]) begin
					next_q.fan_ambient = req.wdata;
				end
			end else if (req.addr == OFS_FAN_REMOTE) begin
				if (!q.config2[CFG_LOCK_REMOTE]) begin
					next_q.fan_remote = req.wdata;
				end
			end else if (req.addr == OFS_IRQ_MASK_FIRST) begin
				next_q.mask_first = req.wdata;
			end else if (req.addr == OFS_IRQ_MASK_SECOND) begin
				next_q.mask_second = req.wdata;
			end else if (req.addr == OFS_INTRUSION_CLEAR) begin
				if (req.wdata[INTRUSION_CLEAR_BIT] && !q.clear_busy) begin
					next_q.clear_busy = 1'b1;
					next_q.pulse_cnt = '0;
				end
			end else if (req.addr == OFS_CORE_CODE_LOW) begin
				next_q.prescale = req.wdata[7:PRESCALE_LSB];
			end else if (req.addr == OFS_SECOND_CONFIG) begin
				// lock bits only ever set until reset or soft_init
				next_q.config2 = req.wdata & CFG2_VALID;
				next_q.config2[CFG_LOCK_AMBIENT] = q.config2[CFG_LOCK_AMBIENT]
					| req.wdata[CFG_LOCK_AMBIENT];
				next_q.config2[CFG_LOCK_REMOTE] = q.config2[CFG_LOCK_REMOTE]
					| req.wdata[CFG_LOCK_REMOTE];
			end
		end

		// intrusion pin low pulse
		if (q.clear_busy) begin
			if (q.pulse_cnt == PULSE_LAST) begin
				next_q.clear_busy = 1'b0;
				next_q.pulse_cnt = '0;
			end else begin
				next_q.pulse_cnt = q.pulse_cnt + 1'b1;
			end
		end

		// status flags: a new event wins over a read clear
		second_flags = 8'h00;
		second_flags[0] = faults.supply12;
		second_flags[1] = faults.second_core_supply;
		second_flags[ST2_INTRUSION] = q.intr_b & !q.intr_prev & !q.clear_busy;
		second_flags[ST2_OVERTEMP] = !q.ovt_b;
		second_flags[6] = faults.remote_diode_first_fault;
		second_flags[7] = faults.remote_diode_second_fault;
		next_q.status_first = (clear_first ? 8'h00 : q.status_first) | first_events;
		next_q.status_second = (clear_second ? 8'h00 : q.status_second)
			| second_flags;

		// alarm output
		first_gated = q.status_first & ~q.mask_first;
		if (q.config2[CFG_THERMAL_MASK]) begin
			first_gated = first_gated & ~THERMAL_FLAGS;
		end
		second_gated = q.status_second & ~q.mask_second & ST2_VALID;
		aux_active = q.aux_b & {q.config2[CFG_AUX_SECOND], q.config2[CFG_AUX_FIRST]}
			& {2{aux_group_irq_mode}};
		next_q.alarm_n = !(|first_gated || |second_gated || |aux_active);

		if (soft_init) begin
			next_q.mask_first = RST_BYTE;
			next_q.mask_second = RST_BYTE;
			next_q.prescale = RST_PRESCALE;
			next_q.config2 = RST_BYTE;
			next_q.status_first = RST_BYTE;
			next_q.status_second = RST_BYTE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
			q.ovt_a <= 1'b1;
			q.ovt_b <= 1'b1;
			q.alarm_n <= 1'b1;
			q.mask_second <= RST_BYTE;
			q.config2 <= RST_BYTE;
		end else begin
			q <= next_q;
		end
	end

	assign rsp = '{valid: q.rsp_valid, rdata: q.rsp_data};
	assign alarm_n = q.alarm_n;
	assign intrusion_flag_out = 1'b0;
	assign intrusion_flag_oe_n = !q.clear_busy;
	assign overtemp_acpi_mode = q.config2[CFG_OVERTEMP_ACPI];
	assign first_tachometer_divide = divide_of(q.prescale[1:0]);
	assign second_tachometer_divide = divide_of(q.prescale[3:2]);
	assign fan_ambient_ctrl = q.fan_ambient;
	assign fan_remote_ctrl = q.fan_remote;

endmodule

`default_nettype wire

// ### inc/monitor_regs_pkg.sv
// package for the monitor mask, configuration and status register bank
// assumes a single 125 MHz core clock and a serial-bus engine on that clock
package monitor_regs_pkg;

	// register offsets
	localparam logic [7:0] OFS_FAN_AMBIENT = 8'h13;
	localparam logic [7:0] OFS_FAN_REMOTE = 8'h14;
	localparam logic [7:0] OFS_STATUS_FIRST = 8'h41;
	localparam logic [7:0] OFS_STATUS_SECOND = 8'h42;
	localparam logic [7:0] OFS_IRQ_MASK_FIRST = 8'h43;
	localparam logic [7:0] OFS_IRQ_MASK_SECOND = 8'h44;
	localparam logic [7:0] OFS_INTRUSION_CLEAR = 8'h46;
	localparam logic [7:0] OFS_CORE_CODE_LOW = 8'h47;
	localparam logic [7:0] OFS_CORE_CODE_HIGH = 8'h49;
	localparam logic [7:0] OFS_SECOND_CONFIG = 8'h4A;
	localparam logic [7:0] OFS_STATUS_FIRST_COPY = 8'h4C;
	localparam logic [7:0] OFS_STATUS_SECOND_COPY = 8'h4D;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_PRESCALE = 4'h0;

	// field positions
	localparam int INTRUSION_CLEAR_BIT = 7;
	localparam int PRESCALE_LSB = 4;
	localparam int CFG_THERMAL_MASK = 0;
	localparam int CFG_LOCK_AMBIENT = 1;
	localparam int CFG_LOCK_REMOTE = 2;
	localparam int CFG_OVERTEMP_ACPI = 3;
	localparam int CFG_AUX_FIRST = 6;
	localparam int CFG_AUX_SECOND = 7;
	localparam int ST2_INTRUSION = 4;
	localparam int ST2_OVERTEMP = 5;
	// thermal flags of the first status byte
	localparam logic [7:0] THERMAL_FLAGS = 8'h30;
	// flags that exist in the second status byte
	localparam logic [7:0] ST2_VALID = 8'hF3;
	localparam logic [7:0] CFG2_VALID = 8'hCF;

	// identity pattern, value arbitrary
	localparam logic [6:0] IDENTITY_PATTERN = 7'h2A;

	// timing
	localparam int CLK_MHZ = 125;
	localparam int INTRUSION_PULSE_MS = 20;
	localparam int INTRUSION_PULSE_CYCLES = INTRUSION_PULSE_MS * CLK_MHZ * 1000;
	localparam int PULSE_CNT_W = 22;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} reg_rsp_s;

	typedef struct packed {
		logic supply12;
		logic second_core_supply;
		logic remote_diode_first_fault;
		logic remote_diode_second_fault;
	} fault_in_s;

endpackage

// ### dv/monitor_regs_chk.sv
// checker for the mask, configuration and intrusion-clear register bank
// bound to the bank's top module; PULSE_CYCLES matches the bound instance
`timescale 1ns/10ps
`default_nettype none
module monitor_regs_chk
	import monitor_regs_pkg::*;
#(
	parameter int PULSE_CYCLES = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_init,
	// register port
	input wire reg_req_s req,
	input wire reg_rsp_s rsp,
	// pins and controls
	input wire logic intrusion_flag_out,
	input wire logic intrusion_flag_oe_n,
	input wire logic overtemp_acpi_mode,
	input wire logic [3:0] first_tachometer_divide,
	input wire logic [3:0] second_tachometer_divide,
	input wire logic [7:0] fan_ambient_ctrl,
	input wire logic [7:0] fan_remote_ctrl
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// cycles the intrusion pin has been driven low
	logic [31:0] low_cnt;
	always_ff @(posedge core_clk) begin
		if (rst || intrusion_flag_oe_n) begin
			low_cnt <= 32'h0;
		end else begin
			low_cnt <= low_cnt + 32'h1;
		end
	end
	// write-once locks as the host has set them
	logic amb_locked;
	logic rem_locked;
	always_ff @(posedge core_clk) begin
		if (rst || soft_init) begin
			amb_locked <= 1'b0;
			rem_locked <= 1'b0;
		end else if (req.wr && req.addr == OFS_SECOND_CONFIG) begin
			amb_locked <= amb_locked | req.wdata[CFG_LOCK_AMBIENT];
			rem_locked <= rem_locked | req.wdata[CFG_LOCK_REMOTE];
		end
	end
	chk_read_answer: assert property (req.rd |=> rsp.valid)
		else $error("read got no answer");
	chk_stray_valid: assert property (!req.rd |=> !rsp.valid)
		else $error("answer without read");
	chk_rdata_hold: assert property (!rsp.valid |-> $stable(rsp.rdata))
		else $error("read data moved between reads");
	chk_pulse_start: assert property ((req.wr && req.addr == OFS_INTRUSION_CLEAR
		&& req.wdata[INTRUSION_CLEAR_BIT] && intrusion_flag_oe_n) |=> !intrusion_flag_oe_n)
		else $error("pulse did not start");
	chk_pulse_length: assert property ($rose(intrusion_flag_oe_n)
		|-> low_cnt == 32'(PULSE_CYCLES)) else $error("pulse length wrong");
	chk_pin_low: assert property (!intrusion_flag_oe_n |-> !intrusion_flag_out)
		else $error("pin not driven low");
	chk_first_divide: assert property ((req.wr && req.addr == OFS_CORE_CODE_LOW)
		|=> first_tachometer_divide == 4'h1 << $past(req.wdata[5:4])) else $error("div1");
	chk_second_divide: assert property ((req.wr && req.addr == OFS_CORE_CODE_LOW)
		|=> second_tachometer_divide == 4'h1 << $past(req.wdata[7:6])) else $error("div2");
	chk_acpi_mode: assert property ((req.wr && req.addr == OFS_SECOND_CONFIG)
		|=> overtemp_acpi_mode == $past(req.wdata[CFG_OVERTEMP_ACPI]))
		else $error("mode bit wrong");
	chk_ambient_lock: assert property ($changed(fan_ambient_ctrl)
		|-> $past(req.wr && req.addr == OFS_FAN_AMBIENT && !amb_locked))
		else $error("ambient changed");
	chk_remote_lock: assert property ($changed(fan_remote_ctrl)
		|-> $past(req.wr && req.addr == OFS_FAN_REMOTE && !rem_locked))
		else $error("remote changed");
	chk_ambient_write: assert property ((req.wr && req.addr == OFS_FAN_AMBIENT
		&& !amb_locked) |=> fan_ambient_ctrl == $past(req.wdata))
		else $error("ambient write lost");
	chk_remote_write: assert property ((req.wr && req.addr == OFS_FAN_REMOTE
		&& !rem_locked) |=> fan_remote_ctrl == $past(req.wdata))
		else $error("remote write lost");
endmodule
`default_nettype wire

// ### dv/monitor_host_model.sv
// serial-bus host model: issues single-byte register writes and reads
// requests launch after a rising edge and drop after the taking edge
`timescale 1ns/10ps
`default_nettype none
module monitor_host_model
	import monitor_regs_pkg::*;
(
	// clock
	input wire logic core_clk,
	// register port
	output reg_req_s req,
	input wire reg_rsp_s rsp
);
	initial req = '0;
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		req <= '0;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge core_clk);
		req <= '0;
		#1;
		d = rsp.rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/monitor_irq_mask_config_regs_tb_top.sv
// top testbench of the mask, configuration and status register bank
// host model drives the register port; intrusion wire resolved here
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module monitor_irq_mask_config_regs_tb_top;
	import monitor_regs_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
	logic core_clk = 0, rst = 1, soft_init = 0, aux_group_irq_mode = 0;
	logic overtemp_signal_n = 1, intrusion_ext = 0, intrusion_flag_out, intrusion_flag_oe_n;
	logic alarm_n, overtemp_acpi_mode;
	logic [7:0] first_events = 0, fan_ambient_ctrl, fan_remote_ctrl, d;
	logic [4:0] core_voltage_code = 5'h15;
	logic [1:0] aux_irq_pin = 0;
	logic [3:0] first_tachometer_divide, second_tachometer_divide;
	fault_in_s faults = '0;
	reg_req_s req;
	reg_rsp_s rsp;
	int n_fail = 0, check_count = 0;
	wire logic intrusion_flag_in = intrusion_flag_oe_n ? intrusion_ext : intrusion_flag_out;
	row_s rows[12] = '{'{8'h44, 8'hFF, 8'hFF}, '{8'h43, 8'hA5, 8'hA5}, '{8'h47, 8'hC0, 8'hC5},
		'{8'h47, 8'h90, 8'h95}, '{8'h49, 8'h00, {IDENTITY_PATTERN, 1'b1}},
		'{8'h46, 8'h00, 8'h00}, '{8'h50, 8'h12, 8'h00}, '{8'h13, 8'h5A, 8'h5A},
		'{8'h14, 8'h77, 8'h77}, '{8'h4A, 8'h3E, 8'h0E}, '{8'h13, 8'h33, 8'h5A},
		'{8'h14, 8'h33, 8'h77}};
	logic [7:0] bits[4] = '{8'h01, 8'h02, 8'h40, 8'h80};
	monitor_host_model h (.core_clk, .req, .rsp);
	monitor_irq_mask_config_regs #(.PULSE_CYCLES(20)) dut (.core_clk, .rst, .soft_init, .req,
		.rsp, .first_events, .faults, .aux_group_irq_mode, .core_voltage_code, .aux_irq_pin,
		.overtemp_signal_n, .intrusion_flag_in, .intrusion_flag_out, .intrusion_flag_oe_n,
		.alarm_n, .overtemp_acpi_mode, .first_tachometer_divide, .second_tachometer_divide,
		.fan_ambient_ctrl, .fan_remote_ctrl);
	task automatic report_and_stop;
		if (n_fail == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic alarm_after(input fault_in_s f, input logic exp);
		@(posedge core_clk) faults <= f;
		@(posedge core_clk) faults <= '0;
		repeat (3) @(posedge core_clk);
		#1 `CHK(alarm_n, exp)
	endtask
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		repeat (4000) @(posedge core_clk);
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		foreach (rows[i]) begin
			h.put(rows[i].a, rows[i].d);
			h.get(rows[i].a, d);
			`CHK(d, rows[i].e)
		end
		`CHK(overtemp_acpi_mode, 1'b1)
		`CHK({first_tachometer_divide, second_tachometer_divide}, 8'h24)
		`CHK({fan_ambient_ctrl, fan_remote_ctrl}, 16'h5A77)
		@(posedge core_clk) rst <= 1;
		repeat (3) @(posedge core_clk);
		rst <= 0;
		foreach (rows[i]) if (rows[i].e != 8'hC5 && rows[i].e != 8'h95 && i != 4) begin
			h.get(rows[i].a, d);
			`CHK(d, 8'h00)
		end
		`CHK(overtemp_acpi_mode, 1'b0)
		`CHK({first_tachometer_divide, second_tachometer_divide}, 8'h11)
		`CHK({fan_ambient_ctrl, fan_remote_ctrl}, 16'h0000)
		h.put(8'h46, 8'h80);
		h.get(8'h46, d);
		`CHK({d, intrusion_flag_oe_n}, 9'h100)
		repeat (25) @(posedge core_clk);
		h.get(8'h46, d);
		`CHK({d, intrusion_flag_oe_n}, 9'h001)
		for (int k = 0; k < 4; k++) begin
			h.put(8'h44, bits[k]);
			alarm_after(fault_in_s'(4'h8 >> k), 1'b1);
			h.get(8'h42, d);
			`CHK(d, bits[k])
		end
		h.put(8'h44, 8'h00);
		alarm_after(fault_in_s'(4'h8), 1'b0);
		h.get(8'h4D, d);
		`CHK(d, 8'h01)
		h.get(8'h42, d);
		`CHK(d, 8'h01)
		repeat (3) @(posedge core_clk);
		#1 `CHK(alarm_n, 1'b1)
		for (int t = 0; t < 2; t++) begin
			h.put(8'h4A, {7'h0, t == 0});
			@(posedge core_clk) first_events <= 8'h10 << t;
			@(posedge core_clk) first_events <= 8'h00;
			repeat (3) @(posedge core_clk);
			#1 `CHK(alarm_n, t == 0)
			h.get(8'h4C, d);
			`CHK(d, 8'h10 << t)
			h.get(8'h41, d);
			`CHK(d, 8'h10 << t)
		end
		for (int m = 0; m < 4; m++) begin
			h.put(8'h4A, 8'h40 << m[0]);
			@(posedge core_clk) aux_group_irq_mode <= m[1];
			aux_irq_pin <= 2'h1 << m[0];
			repeat (4) @(posedge core_clk);
			#1 `CHK(alarm_n, !m[1])
			@(posedge core_clk) aux_irq_pin <= 2'h0;
		end
		h.put(8'h4A, 8'h06);
		h.put(8'h13, 8'h11);
		h.get(8'h13, d);
		`CHK(d, 8'h00)
		@(posedge core_clk) soft_init <= 1;
		@(posedge core_clk) soft_init <= 0;
		h.get(8'h4A, d);
		`CHK(d, 8'h00)
		h.put(8'h13, 8'h11);
		h.put(8'h14, 8'h22);
		h.get(8'h14, d);
		`CHK({d, fan_ambient_ctrl}, 16'h2211)
		@(posedge core_clk) overtemp_signal_n <= 0;
		intrusion_ext <= 1;
		repeat (4) @(posedge core_clk);
		h.get(8'h42, d);
		`CHK(d, 8'h30)
		`CHK(alarm_n, 1'b0)
		report_and_stop();
	end
endmodule
bind monitor_irq_mask_config_regs monitor_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
	.core_clk, .rst, .soft_init, .req, .rsp, .intrusion_flag_out, .intrusion_flag_oe_n,
	.overtemp_acpi_mode, .first_tachometer_divide, .second_tachometer_divide,
	.fan_ambient_ctrl, .fan_remote_ctrl);
`default_nettype wire
